// file: serial_flash_command_engine_test.sv
// Self-checking bench of the serial flash command engine
`timescale 1ns/10ps
`default_nettype none
`include "sfce_params.svh"
module serial_flash_command_engine_test;
   import sfce_pkg::*;
   logic clk_i, reset_i, sel_n, sclk, mosi, miso, oe, wv, wr, es, eb, busy, write_enable_flag, sb, sbusy;
   logic [2:0] prot;
   logic [1:0] pm;
   logic [7:0] rd_data, wdat, esec;
   logic [23:0] rd_addr, wadr;
   logic [7:0] pmem [logic [23:0]];
   int miscompares = 0;
   int compares = 0;
   int cyc = 0;
   int n_erase = 0;
   int n_oe = 0;
   sfce_host u_host (.clk_i(clk_i), .sel_n_o(sel_n), .sclk_o(sclk), .sdo_o(mosi), .sdi_i(miso));
   // Short timers keep the run brief; signature wake delays keep their defaults
   sfce_engine #(.PROG_CYC(16'd40), .SERASE_CYC(16'd40), .BERASE_CYC(16'd40),
      .DPD_CYC(16'd4), .WAKE_CYC(16'd4)) DUT (.clk_i(clk_i), .reset_i(reset_i), .sel_n_i(sel_n),
      .sclk_i(sclk), .serial_in_i(mosi), .serial_out_o(miso), .serial_out_oe_o(oe),
      .protect_level_i(prot), .status_cycle_busy_i(sbusy), .mem_rd_addr_o(rd_addr),
      .mem_rd_data_i(rd_data), .prog_wr_valid_o(wv), .prog_wr_ready_i(wr),
      .prog_wr_addr_o(wadr), .prog_wr_data_o(wdat), .erase_start_o(es), .erase_bulk_o(eb),
      .erase_sector_o(esec), .busy_flag_o(busy), .write_enable_flag_o(write_enable_flag),
      .power_mode_o(pm), .standby_o(sb));
   initial
   begin
      clk_i = 1'b0;
      forever #12.5 clk_i = ~clk_i;
   end
   // Array stalls every other cycle
   always @(posedge clk_i)
   begin
      rd_data <= rd_addr[7:0] ^ 8'h5a;
      wr <= cyc[0];
      if (oe)
         n_oe++;
      if (wv && wr)
         pmem[wadr] = wdat;
      if (es)
         n_erase++;
      cyc++;
      if (cyc == 30000)
      begin
         miscompares++;
         finish_test();
      end
   end
   task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
      compares++;
      if (got !== exp)
      begin
         miscompares++;
         $display("unexpected %s expected %h seen %h", what, exp, got);
      end
   endtask : check
   task automatic wait_idle;
      for (int i = 0; i < 2000 && busy !== 1'b0; i++)
         @(posedge clk_i);
      check("busy", 0, busy);
   endtask : wait_idle
   task automatic t_read;
      u_host.frame('{8'h0b, 8'hff, 8'hff, 8'hfe, 8'h00}, 3);
      check("rd0", 8'ha4, u_host.rx[0]);
      check("rd1", 8'ha5, u_host.rx[1]);
      check("rd2", 8'h5a, u_host.rx[2]);
      check("sb", 1, sb);
   endtask : t_read
   task automatic t_prog;
      u_host.frame('{8'h02, 8'h00, 8'h01, 8'h10, 8'haa}, 0);
      check("busy", 0, busy);
      check("nwr", 0, pmem.num());
      u_host.frame('{8'h06}, 0);
      check("wel", 1, write_enable_flag);
      u_host.frame('{8'h02, 8'h00, 8'h01, 8'hfe, 8'h11, 8'h22, 8'h33}, 0);
      check("busy", 1, busy);
      wait_idle();
      check("wel", 0, write_enable_flag);
      check("w1ff", 8'h22, pmem[24'h0001ff]);
      check("w100", 8'h33, pmem[24'h000100]);
      check("nwr", 3, pmem.num());
   endtask : t_prog
   task automatic t_erase;
      u_host.frame('{8'h06}, 0);
      prot <= 3'h7;
      u_host.frame('{8'h02, 8'hff, 8'h00, 8'h00, 8'h00}, 0);
      check("nwr", 3, pmem.num());
      u_host.frame('{8'hd8, 8'hff, 8'h00, 8'h00}, 0);
      check("ner", 0, n_erase);
      prot <= 3'h1;
      u_host.frame('{8'hc7}, 0);
      check("ner", 0, n_erase);
      check("wel", 1, write_enable_flag);
      prot <= 3'h0;
      u_host.frame('{8'hc7}, 0);
      check("ner", 1, n_erase);
      check("bulk", 1, eb);
      wait_idle();
      check("wel", 0, write_enable_flag);
      u_host.frame('{8'h06}, 0);
      u_host.frame('{8'hd8, 8'h12, 8'h34, 8'h56}, 0);
      check("sect", 8'h12, esec);
      check("bulk", 0, eb);
      wait_idle();
   endtask : t_erase
   task automatic t_busy;
      int n0;
      n0 = n_oe;
      sbusy <= 1'b1;
      u_host.frame('{8'h0b, 8'h00, 8'h00, 8'h00, 8'h00}, 1);
      u_host.frame('{8'hab, 8'h00, 8'h00, 8'h00}, 1);
      u_host.frame('{8'hb9}, 0);
      repeat (20) @(posedge clk_i);
      check("oe", n0, n_oe);
      check("pm", PW_STANDBY, pm);
      sbusy <= 1'b0;
   endtask : t_busy
   task automatic t_power;
      int n0;
      u_host.frame('{8'hb9}, 0);
      repeat (20) @(posedge clk_i);
      check("pm", PW_DEEP, pm);
      n0 = n_oe;
      u_host.frame('{8'h06}, 0);
      u_host.frame('{8'h0b, 8'h00, 8'h00, 8'h00, 8'h00}, 1);
      check("oe", n0, n_oe);
      check("wel", 0, write_enable_flag);
      u_host.frame('{8'hab}, 0);
      repeat (20) @(posedge clk_i);
      check("pm", PW_STANDBY, pm);
      u_host.rx.delete();
      u_host.frame('{8'hab, 8'h00, 8'h00, 8'h00}, 2);
      check("sig0", `SFCE_SIG_DEFAULT, u_host.rx[0]);
      check("sig1", `SFCE_SIG_DEFAULT, u_host.rx[1]);
   endtask : t_power
   // Signature wake from deep power-down, cut before output and after it
   task automatic t_wake;
      u_host.frame('{8'hb9}, 0);
      repeat (20) @(posedge clk_i);
      u_host.frame('{8'hab, 8'h00, 8'h00, 8'h00}, 0);
      check("pm", PW_WAKE, pm);
      repeat (`SFCE_CYC_DN(`SFCE_T_WAKE_SHORT_NS)) @(posedge clk_i);
      check("pm", PW_STANDBY, pm);
      u_host.frame('{8'hb9}, 0);
      repeat (20) @(posedge clk_i);
      u_host.frame('{8'hab, 8'h00, 8'h00, 8'h00}, 1);
      check("sig2", `SFCE_SIG_DEFAULT, u_host.rx[2]);
      repeat (`SFCE_CYC_DN(`SFCE_T_WAKE_SHORT_NS)) @(posedge clk_i);
      check("pm", PW_WAKE, pm);
      repeat (`SFCE_CYC_DN(`SFCE_T_WAKE_LONG_NS)) @(posedge clk_i);
      check("pm", PW_STANDBY, pm);
   endtask : t_wake
   task automatic finish_test;
      if (miscompares == 0 && compares > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask : finish_test
   initial
   begin
      reset_i = 1'b1;
      prot = 3'h0;
      sbusy = 1'b0;
      repeat (3) @(posedge clk_i);
      reset_i <= 1'b0;
      repeat (4) @(posedge clk_i);
      t_read();
      t_prog();
      t_erase();
      t_busy();
      t_power();
      t_wake();
      finish_test();
   end
endmodule : serial_flash_command_engine_test
`default_nettype wire

// file: sfce_buf2.sv
// Small FIFO with valid and ready on both sides, two entries by default
`timescale 1ns/10ps
`default_nettype none
module sfce_buf2 #(
   parameter int W = 32,
   parameter int DEPTH = 2
) (
   input wire logic clk_i, // System clock
   input wire logic reset_i, // Asynchronous reset, active high
   input wire logic in_valid_i, // Word offered
   output logic in_ready_o, // Room for a word
   input wire logic [W-1:0] in_data_i, // Word in
   output logic out_valid_o, // Word available
   input wire logic out_ready_i, // Receiver takes word
   output logic [W-1:0] out_data_o // Word out
);
   localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
   localparam int CW = $clog2(DEPTH + 1);
   logic [W-1:0] mem [0:DEPTH-1];
   logic [PW-1:0] wr_ptr_reg;
   logic [PW-1:0] rd_ptr_reg;
   logic [CW-1:0] cnt_reg;
   wire push = in_valid_i && in_ready_o;
   wire pop = out_valid_o && out_ready_i;

   assign in_ready_o = (cnt_reg != CW'(DEPTH));
   assign out_valid_o = (cnt_reg != '0);
   assign out_data_o = mem[rd_ptr_reg];

   always_ff @(posedge clk_i)
   begin
      if (push)
         mem[wr_ptr_reg] <= in_data_i;
   end

   always_ff @(posedge clk_i or posedge reset_i)
   begin
      if (reset_i)
      begin
         wr_ptr_reg <= '0;
         rd_ptr_reg <= '0;
         cnt_reg <= '0;
      end
      else
      begin
         if (push)
            wr_ptr_reg <= (wr_ptr_reg == PW'(DEPTH - 1)) ? '0 : wr_ptr_reg + 1'b1;
         if (pop)
            rd_ptr_reg <= (rd_ptr_reg == PW'(DEPTH - 1)) ? '0 : rd_ptr_reg + 1'b1;
         if (push && !pop)
            cnt_reg <= cnt_reg + 1'b1;
         else if (pop && !push)
            cnt_reg <= cnt_reg - 1'b1;
      end
   end
endmodule : sfce_buf2
`default_nettype wire

// file: sfce_engine.sv
// Command decoder and sequencer of a serial NOR flash behind a four-wire link
// Contract
// - Fast read takes opcode, 24-bit address, dummy byte; data leaves on falling edges.
// - Read address increments per byte, wraps to zero, ends on deselect.
// - Fast read, power-down and release are rejected during a running cycle.
// - Program and erases need the write-enable flag, set by write enable.
// - Program data past the page end wraps to the page start.
// - Only the last 256 bytes program; unaddressed page bytes stay untouched.
// - Program runs only if deselect follows a whole final data byte.
// - Program cycle sets busy for its time; write-enable clears before it ends.
// - Program into a protected page is not executed.
// - Sector erase is opcode plus address; any address selects its sector.
// - Sector erase needs deselect after exactly the address; busy, flag cleared.
// - Sector erase into a protected sector is not executed.
// - Bulk erase is the opcode alone; busy during it, flag cleared.
// - Bulk erase runs only when all protect level bits are zero.
// - Power-down opcode alone enters deep power-down after the entry delay.
// - Deselect gives standby when no internal cycle is running; standby_o is not held off by a status write cycle.
// - In deep power-down only release and signature read are served.
// - Release is the opcode alone; extra clocks reject; standby after wake delay.
// - Signature read sends opcode and three dummies; signature repeats while clocked.
// - Signature read works awake too, but never during a running cycle.
// - Signature wake uses short delay if deselected before a whole signature byte is out, else long.
`timescale 1ns/10ps
`default_nettype none
`include "sfce_params.svh"
module sfce_engine
   import sfce_pkg::*;
#(
   parameter logic [15:0] PROG_CYC = 16'(`SFCE_CYC_UP(`SFCE_T_PROG_NS)),
   parameter logic [15:0] SERASE_CYC = 16'(`SFCE_CYC_UP(`SFCE_T_SERASE_NS)),
   parameter logic [15:0] BERASE_CYC = 16'(`SFCE_CYC_UP(`SFCE_T_BERASE_NS)),
   parameter logic [15:0] DPD_CYC = 16'(`SFCE_CYC_DN(`SFCE_T_DPD_NS)),
   parameter logic [15:0] WAKE_CYC = 16'(`SFCE_CYC_DN(`SFCE_T_WAKE_NS)),
   parameter logic [15:0] WAKE_SHORT_CYC = 16'(`SFCE_CYC_DN(`SFCE_T_WAKE_SHORT_NS)),
   parameter logic [15:0] WAKE_LONG_CYC = 16'(`SFCE_CYC_DN(`SFCE_T_WAKE_LONG_NS)),
   parameter logic [7:0] SIGNATURE = `SFCE_SIG_DEFAULT // Arbitrary value
) (
   input wire logic clk_i, // System clock, 40 MHz
   input wire logic reset_i, // Asynchronous reset, active high
   input wire logic sel_n_i, // Link select pin, active low
   input wire logic sclk_i, // Link clock pin
   input wire logic serial_in_i, // Link data from host
   output logic serial_out_o, // Link data to host
   output logic serial_out_oe_o, // Drive enable of serial_out
   input wire logic [2:0] protect_level_i, // Block protect bits
   input wire logic status_cycle_busy_i, // Status write cycle running
   output logic [`SFCE_ADDR_W-1:0] mem_rd_addr_o, // Array read address
   input wire logic [7:0] mem_rd_data_i, // Array read data
   output logic prog_wr_valid_o, // Program word offered
   input wire logic prog_wr_ready_i, // Array takes program word
   output logic [`SFCE_ADDR_W-1:0] prog_wr_addr_o, // Program byte address
   output logic [7:0] prog_wr_data_o, // Program byte
   output logic erase_start_o, // Erase start pulse
   output logic erase_bulk_o, // Erase covers whole array
   output logic [`SFCE_SECT_W-1:0] erase_sector_o, // Sector to erase
   output logic busy_flag_o, // Internal cycle running
   output logic write_enable_flag_o, // Write enable flag
   output logic [1:0] power_mode_o, // Power state
   output logic standby_o // Idle in standby power
);
   localparam int AW = `SFCE_ADDR_W;
   localparam int NPAGE = 1 << `SFCE_PAGE_W;

   function automatic logic prot_hit(input logic [2:0] bp, input logic [7:0] sec);
      logic [8:0] first;
      first = 9'h100 - (9'h001 << (bp - 3'h1));
      prot_hit = (bp == 3'h7) || ((bp != 3'h0) && ({1'b0, sec} >= first));
   endfunction : prot_hit

   // Pins come from the host's domain
   logic [2:0] sync1_reg;
   logic [2:0] sync2_reg;
   logic sclk_prev_reg;
   logic sel_prev_reg;
   always_ff @(posedge clk_i or posedge reset_i)
   begin
      if (reset_i)
      begin
         sync1_reg <= 3'h1;
         sync2_reg <= 3'h1;
         sclk_prev_reg <= 1'b0;
         sel_prev_reg <= 1'b1;
      end
      else
      begin
         sync1_reg <= {serial_in_i, sclk_i, sel_n_i};
         sync2_reg <= sync1_reg;
         sclk_prev_reg <= sync2_reg[1];
         sel_prev_reg <= sync2_reg[0];
      end
   end
   wire sel_n_s = sync2_reg[0];
   wire din_s = sync2_reg[2];
   wire sclk_rise = sync2_reg[1] && !sclk_prev_reg && !sel_n_s;
   wire sclk_fall = !sync2_reg[1] && sclk_prev_reg && !sel_n_s;
   wire sel_fall = !sel_n_s && sel_prev_reg;
   wire desel = sel_n_s && !sel_prev_reg;

   sfce_rx_t rx_reg;
   sfce_pwr_t pwr_reg;
   sfce_cyc_t cy_reg;
   logic [7:0] opc_reg;
   logic [7:0] shift_reg;
   logic [5:0] bits_reg;
   logic [2:0] bit_cnt_reg;
   logic [AW-1:0] addr_reg;
   logic [AW-1:0] rd_addr_reg;
   logic [7:0] page_ptr_reg;
   logic [7:0] out_shift_reg;
   logic [2:0] out_cnt_reg;
   logic so_reg;
   logic sig_shown_reg;
   logic wel_reg;
   logic [15:0] timer_reg;
   logic [15:0] ptimer_reg;
   logic [8:0] scan_reg;
   logic [NPAGE-1:0] page_vld_reg;
   logic [7:0] page_mem [0:NPAGE-1];
   logic erase_start_reg;
   logic erase_bulk_reg;
   logic [`SFCE_SECT_W-1:0] erase_sector_reg;

   // Byte assembly on rising link edges
   wire [7:0] byte_in = {shift_reg[6:0], din_s};
   wire byte_done = sclk_rise && (bit_cnt_reg == 3'h7);
   wire [5:0] bits_inc = (bits_reg == `SFCE_BITS_SAT) ? bits_reg : bits_reg + 6'd1;
   wire busy = (cy_reg != CY_IDLE) || status_cycle_busy_i;
   wire deep = (pwr_reg == PW_DEEP);
   wire awake = (pwr_reg == PW_STANDBY);
   wire [AW-1:0] addr_full = {addr_reg[AW-9:0], byte_in};

   // Opcode routing; rejected commands drop to RX_IGNORE with no side effect
   sfce_rx_t route;
   always_comb
   begin
      route = RX_IGNORE;
      if (!busy && (awake || deep))
      begin
         case (byte_in)
            `SFCE_OP_WAKE: route = RX_DUMMY;
            `SFCE_OP_FREAD, `SFCE_OP_PROG, `SFCE_OP_SERASE: route = deep ? RX_IGNORE : RX_ADDR;
            `SFCE_OP_WREN, `SFCE_OP_BERASE, `SFCE_OP_DPD: route = deep ? RX_IGNORE : RX_HOLD;
            default: route = RX_IGNORE;
         endcase
      end
   end

   wire addr_last = byte_done && (rx_reg == RX_ADDR) && (bits_inc == `SFCE_BITS_ADDR);
   wire out_begin = byte_done && (rx_reg == RX_DUMMY) &&
      (((opc_reg == `SFCE_OP_FREAD) && (bits_inc == `SFCE_BITS_DUMMY)) ||
       ((opc_reg == `SFCE_OP_WAKE) && (bits_inc == `SFCE_BITS_ADDR)));
   wire pg_clr = byte_done && (rx_reg == RX_IDLE) && (bits_reg == 6'd7) &&
      (route == RX_ADDR) && (byte_in == `SFCE_OP_PROG);
   wire pg_we = byte_done && (rx_reg == RX_PDATA);
   wire out_load = sclk_fall && (rx_reg == RX_OUT) && (out_cnt_reg == 3'h0);
   wire [7:0] out_src = (opc_reg == `SFCE_OP_FREAD) ? mem_rd_data_i : SIGNATURE;

   // Execution is decided at deselect from the exact bit count seen, except program (whole bytes) and signature wake
   wire [7:0] tgt_sec = addr_reg[`SFCE_SECT_LSB +: `SFCE_SECT_W];
   wire wr_ok = wel_reg && !busy && awake;
   wire wren_go = desel && (rx_reg == RX_HOLD) && (opc_reg == `SFCE_OP_WREN) &&
      (bits_reg == `SFCE_BITS_OPC) && !busy && awake;
   wire prog_go = desel && (rx_reg == RX_PDATA) && (bits_reg >= `SFCE_BITS_DUMMY) &&
      (bit_cnt_reg == 3'h0) && wr_ok && !prot_hit(protect_level_i, tgt_sec);
   wire se_go = desel && (rx_reg == RX_HOLD) && (opc_reg == `SFCE_OP_SERASE) &&
      (bits_reg == `SFCE_BITS_ADDR) && wr_ok && !prot_hit(protect_level_i, tgt_sec);
   wire be_go = desel && (rx_reg == RX_HOLD) && (opc_reg == `SFCE_OP_BERASE) &&
      (bits_reg == `SFCE_BITS_OPC) && wr_ok && (protect_level_i == 3'h0);
   wire dpd_go = desel && (rx_reg == RX_HOLD) && (opc_reg == `SFCE_OP_DPD) &&
      (bits_reg == `SFCE_BITS_OPC) && !busy && awake;
   wire res_go = desel && (rx_reg == RX_DUMMY) && (opc_reg == `SFCE_OP_WAKE) &&
      (bits_reg == `SFCE_BITS_OPC) && !busy && deep;
   wire sig_go = desel && (rx_reg == RX_OUT) && (opc_reg == `SFCE_OP_WAKE) && deep;
   wire cy_start = prog_go || se_go || be_go;

   // Receive side
   always_ff @(posedge clk_i or posedge reset_i)
   begin
      if (reset_i)
      begin
         rx_reg <= RX_IDLE;
         opc_reg <= 8'h00;
         shift_reg <= 8'h00;
         bits_reg <= 6'd0;
         bit_cnt_reg <= 3'h0;
         addr_reg <= '0;
         page_ptr_reg <= 8'h00;
      end
      else if (sel_fall)
      begin
         rx_reg <= RX_IDLE;
         bits_reg <= 6'd0;
         bit_cnt_reg <= 3'h0;
      end
      else if (sclk_rise)
      begin
         shift_reg <= byte_in;
         bits_reg <= bits_inc;
         bit_cnt_reg <= bit_cnt_reg + 3'h1;
         if (byte_done && (rx_reg == RX_IDLE))
         begin
            opc_reg <= byte_in;
            rx_reg <= route;
         end
         if (byte_done && (rx_reg == RX_ADDR))
            addr_reg <= addr_full;
         if (addr_last)
         begin
            page_ptr_reg <= byte_in;
            rx_reg <= (opc_reg == `SFCE_OP_FREAD) ? RX_DUMMY :
               (opc_reg == `SFCE_OP_PROG) ? RX_PDATA : RX_HOLD;
         end
         if (out_begin)
            rx_reg <= RX_OUT;
         if (pg_we)
            page_ptr_reg <= page_ptr_reg + 8'h01;
      end
   end

   // Page image; no reset, only bytes flagged valid are ever used
   always_ff @(posedge clk_i)
   begin
      if (pg_we)
         page_mem[page_ptr_reg] <= byte_in;
   end

   always_ff @(posedge clk_i or posedge reset_i)
   begin
      if (reset_i)
         page_vld_reg <= '0;
      else if (pg_clr)
         page_vld_reg <= '0;
      else if (pg_we)
         page_vld_reg[page_ptr_reg] <= 1'b1;
   end

   // Transmit side, one bit per falling link edge
   always_ff @(posedge clk_i or posedge reset_i)
   begin
      if (reset_i)
      begin
         rd_addr_reg <= '0;
         out_shift_reg <= 8'h00;
         out_cnt_reg <= 3'h0;
         so_reg <= 1'b0;
         sig_shown_reg <= 1'b0;
      end
      else if (sel_fall)
      begin
         out_cnt_reg <= 3'h0;
         sig_shown_reg <= 1'b0;
      end
      else
      begin
         if (addr_last)
            rd_addr_reg <= addr_full;
         if (sclk_fall && (rx_reg == RX_OUT))
         begin
            out_cnt_reg <= out_cnt_reg + 3'h1;
            if (out_cnt_reg == 3'h7)
               sig_shown_reg <= 1'b1;
            if (out_load)
            begin
               so_reg <= out_src[7];
               out_shift_reg <= {out_src[6:0], 1'b0};
               if (opc_reg == `SFCE_OP_FREAD)
                  rd_addr_reg <= rd_addr_reg + AW'(1);
            end
            else
            begin
               so_reg <= out_shift_reg[7];
               out_shift_reg <= {out_shift_reg[6:0], 1'b0};
            end
         end
      end
   end

   // Self-timed cycles; drain stalls on the array, so busy may outlast the timer
   wire scan_live = (cy_reg == CY_PROG) && !scan_reg[8];
   wire scan_vld = page_vld_reg[scan_reg[7:0]];
   wire buf_in_ready;
   wire buf_out_valid;
   wire scan_adv = scan_live && (!scan_vld || buf_in_ready);
   wire cy_done = (timer_reg == 16'h0000) &&
      ((cy_reg != CY_PROG) || (scan_reg[8] && !buf_out_valid));
   wire [15:0] cy_len = prog_go ? PROG_CYC : se_go ? SERASE_CYC : BERASE_CYC;

   always_ff @(posedge clk_i or posedge reset_i)
   begin
      if (reset_i)
      begin
         cy_reg <= CY_IDLE;
         timer_reg <= 16'h0000;
         scan_reg <= 9'h000;
         wel_reg <= `SFCE_WEL_RST;
         erase_start_reg <= 1'b0;
         erase_bulk_reg <= 1'b0;
         erase_sector_reg <= '0;
      end
      else
      begin
         erase_start_reg <= se_go || be_go;
         if (wren_go)
            wel_reg <= 1'b1;
         else if (cy_start)
            wel_reg <= 1'b0;
         if (cy_start)
         begin
            cy_reg <= prog_go ? CY_PROG : CY_ERASE;
            timer_reg <= cy_len - 16'h0001;
            scan_reg <= 9'h000;
            erase_bulk_reg <= be_go;
            erase_sector_reg <= tgt_sec;
         end
         else
         begin
            if (timer_reg != 16'h0000)
               timer_reg <= timer_reg - 16'h0001;
            if (scan_adv)
               scan_reg <= scan_reg + 9'h001;
            if ((cy_reg != CY_IDLE) && cy_done)
               cy_reg <= CY_IDLE;
         end
      end
   end

   sfce_buf2 #(
      .W(AW + 8),
      .DEPTH(2)
   ) u_prog_buf (
      .clk_i(clk_i),
      .reset_i(reset_i),
      .in_valid_i(scan_live && scan_vld),
      .in_ready_o(buf_in_ready),
      .in_data_i({addr_reg[AW-1:8], scan_reg[7:0], page_mem[scan_reg[7:0]]}),
      .out_valid_o(buf_out_valid),
      .out_ready_i(prog_wr_ready_i),
      .out_data_o({prog_wr_addr_o, prog_wr_data_o})
   );

   // Power modes
   always_ff @(posedge clk_i or posedge reset_i)
   begin
      if (reset_i)
      begin
         pwr_reg <= PW_STANDBY;
         ptimer_reg <= 16'h0000;
      end
      else
      begin
         if (ptimer_reg != 16'h0000)
            ptimer_reg <= ptimer_reg - 16'h0001;
         case (pwr_reg)
            PW_STANDBY:
               if (dpd_go)
               begin
                  pwr_reg <= PW_ENTRY;
                  ptimer_reg <= DPD_CYC - 16'h0001;
               end
            PW_ENTRY:
               if (ptimer_reg == 16'h0000)
                  pwr_reg <= PW_DEEP;
            PW_DEEP:
               if (res_go || sig_go)
               begin
                  pwr_reg <= PW_WAKE;
                  ptimer_reg <= res_go ? WAKE_CYC - 16'h0001 :
                     sig_shown_reg ? WAKE_LONG_CYC - 16'h0001 : WAKE_SHORT_CYC - 16'h0001;
               end
            PW_WAKE:
               if (ptimer_reg == 16'h0000)
                  pwr_reg <= PW_STANDBY;
            default:
               pwr_reg <= PW_STANDBY;
         endcase
      end
   end

   assign serial_out_o = so_reg;
   assign serial_out_oe_o = (rx_reg == RX_OUT) && !sel_n_s;
   assign mem_rd_addr_o = rd_addr_reg;
   assign prog_wr_valid_o = buf_out_valid;
   assign erase_start_o = erase_start_reg;
   assign erase_bulk_o = erase_bulk_reg;
   assign erase_sector_o = erase_sector_reg;
   assign busy_flag_o = busy;
   assign write_enable_flag_o = wel_reg;
   assign power_mode_o = pwr_reg;
   assign standby_o = awake && sel_n_s && (cy_reg == CY_IDLE);

   a_busy_after_start: assert property (@(posedge clk_i) disable iff (reset_i)
      cy_start |=> busy_flag_o && !write_enable_flag_o)
      else $error("cycle start did not raise busy and clear write enable");
   a_run_undisturbed: assert property (@(posedge clk_i) disable iff (reset_i)
      (desel && cy_reg != CY_IDLE) |=> cy_reg == $past(cy_reg) || $past(cy_done))
      else $error("running cycle disturbed by a command");
   a_prog_needs_wel: assert property (@(posedge clk_i) disable iff (reset_i)
      $rose(cy_reg == CY_PROG) |-> $past(wel_reg))
      else $error("program started without write enable");
   a_bulk_unprot: assert property (@(posedge clk_i) disable iff (reset_i)
      (erase_start_o && erase_bulk_o) |-> $past(protect_level_i) == 3'h0)
      else $error("bulk erase with protection set");
   a_deep_ignores: assert property (@(posedge clk_i) disable iff (reset_i)
      (deep && desel && opc_reg != `SFCE_OP_WAKE) |=> (deep && !busy_flag_o)[*2])
      else $error("command served in deep power-down");
   a_read_increments: assert property (@(posedge clk_i) disable iff (reset_i)
      (out_load && opc_reg == `SFCE_OP_FREAD) |=> mem_rd_addr_o == $past(mem_rd_addr_o) + AW'(1))
      else $error("read address did not advance");
   a_drive_only_out: assert property (@(posedge clk_i) disable iff (reset_i)
      serial_out_oe_o |-> (opc_reg == `SFCE_OP_FREAD || opc_reg == `SFCE_OP_WAKE) &&
         cy_reg == CY_IDLE)
      else $error("output driven outside data phase");
   a_entry_delay: assert property (@(posedge clk_i) disable iff (reset_i)
      dpd_go |=> (pwr_reg == PW_ENTRY) ##[1:1000] (pwr_reg == PW_DEEP))
      else $error("deep power-down not entered in time");
   a_prot_page: assert property (@(posedge clk_i) disable iff (reset_i)
      (desel && rx_reg == RX_PDATA && prot_hit(protect_level_i, tgt_sec)) |=> cy_reg == CY_IDLE)
      else $error("protected page programmed");
endmodule : sfce_engine
`default_nettype wire

// file: sfce_host.sv
// Link host model: select, clock and data toward the engine
`timescale 1ns/10ps
`default_nettype none
module sfce_host (
   output logic sel_n_o, // Select, active low
   output logic sclk_o, // Link clock, still between frames
   output logic sdo_o, // Data toward engine
   input wire logic sdi_i, // Data from engine
   input wire logic clk_i // System clock
);
   logic [7:0] rx_byte;
   logic [7:0] rx[$];
   initial
   begin
      sel_n_o = 1'b1;
      sclk_o = 1'b0;
      sdo_o = 1'b0;
   end
   // Long low phase so the engine's delayed output has settled
   task automatic bit_x(input logic d);
      @(posedge clk_i);
      sclk_o <= 1'b0;
      sdo_o <= d;
      repeat (5) @(posedge clk_i);
      sclk_o <= 1'b1;
      rx_byte = {rx_byte[6:0], sdi_i};
      repeat (2) @(posedge clk_i);
   endtask : bit_x
   task automatic frame(input logic [7:0] tx[$], input int nrd);
      @(posedge clk_i);
      sel_n_o <= 1'b0;
      repeat (3) @(posedge clk_i);
      foreach (tx[i])
         for (int k = 7; k >= 0; k--)
            bit_x(tx[i][k]);
      for (int n = 0; n < nrd; n++)
      begin
         for (int k = 0; k < 8; k++)
            bit_x(~sdo_o);
         rx.push_back(rx_byte);
      end
      @(posedge clk_i);
      sclk_o <= 1'b0;
      repeat (3) @(posedge clk_i);
      sel_n_o <= 1'b1;
      sdo_o <= ~sdo_o;
      repeat (12) @(posedge clk_i);
   endtask : frame
endmodule : sfce_host
`default_nettype wire

// file: sfce_params.svh
// Constants of the serial flash command engine: opcodes, layout and timing
`ifndef SFCE_PARAMS_SVH
`define SFCE_PARAMS_SVH
`define SFCE_CLK_NS 25
`define SFCE_ADDR_W 24
`define SFCE_SECT_LSB 16
`define SFCE_SECT_W 8
`define SFCE_PAGE_W 8
`define SFCE_OP_WREN 8'h06
`define SFCE_OP_FREAD 8'h0b
`define SFCE_OP_PROG 8'h02
`define SFCE_OP_SERASE 8'hd8
`define SFCE_OP_BERASE 8'hc7
`define SFCE_OP_DPD 8'hb9
`define SFCE_OP_WAKE 8'hab
`define SFCE_BITS_OPC 6'd8
`define SFCE_BITS_ADDR 6'd32
`define SFCE_BITS_DUMMY 6'd40
`define SFCE_BITS_SAT 6'h3f
`define SFCE_WEL_RST 1'b0
`define SFCE_SIG_DEFAULT 8'h3c
`define SFCE_T_PROG_NS 3000
`define SFCE_T_SERASE_NS 6000
`define SFCE_T_BERASE_NS 12000
`define SFCE_T_DPD_NS 3000
`define SFCE_T_WAKE_NS 3000
`define SFCE_T_WAKE_SHORT_NS 3000
`define SFCE_T_WAKE_LONG_NS 30000
`define SFCE_CYC_UP(t) (((t) + `SFCE_CLK_NS - 1) / `SFCE_CLK_NS)
`define SFCE_CYC_DN(t) ((t) / `SFCE_CLK_NS)
`endif

// file: sfce_pkg.sv
// Types of the serial flash command engine
package sfce_pkg;
   typedef enum logic [2:0] {
      RX_IDLE = 3'h0,
      RX_ADDR = 3'h1,
      RX_DUMMY = 3'h2,
      RX_PDATA = 3'h3,
      RX_OUT = 3'h4,
      RX_HOLD = 3'h5,
      RX_IGNORE = 3'h6
   } sfce_rx_t;
   typedef enum logic [1:0] {
      PW_STANDBY = 2'h0,
      PW_ENTRY = 2'h1,
      PW_DEEP = 2'h2,
      PW_WAKE = 2'h3
   } sfce_pwr_t;
   typedef enum logic [1:0] {
      CY_IDLE = 2'h0,
      CY_PROG = 2'h1,
      CY_ERASE = 2'h2
   } sfce_cyc_t;
endpackage : sfce_pkg
